// ==== bench/reg_host.sv ====
// host model making single-byte register transfers
`timescale 1ns/1ns
`default_nettype none
module reg_host (
   input  wire        clk_in,
   output logic       wr_out, rd_out,
   output logic [7:0] addr_out, wdata_out
);
   initial {wr_out, rd_out, addr_out, wdata_out} = 18'h0;
   // fields held through the taking edge; afterwards the bus shows junk
   task automatic xfer(input logic w, input logic [7:0] a, dt);
      @(negedge clk_in);
      {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, dt};
      @(negedge clk_in);
      {wr_out, rd_out, addr_out, wdata_out} = {2'b00, ~a, ~dt};
   endtask
endmodule // reg_host
`default_nettype wire

// ==== bench/status_irq_regs_monitor.sv ====
// port checks of the status and fault register bank
`timescale 1ns/1ns
`default_nettype none
module status_irq_regs_monitor (
   input wire       CLOCK_IN, RST_IN, REG_WR_IN, REG_RD_IN, REG_RVALID_OUT,
   input wire [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT,
   input wire [3:0] CHAN_ENABLE_IN,
   input wire       ALL_OUTPUTS_ENABLE_IN, INT_PIN_OUT, ADJ_DIRECTION_OUT,
   input wire [5:0] OUT_ENABLE_IN,
   input wire [6:0] ADJ_CURRENT_CODE_OUT
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);
   wire [5:0] g = OUT_ENABLE_IN & {6{ALL_OUTPUTS_ENABLE_IN}};
   wire rd_a = REG_RD_IN && REG_ADDR_IN == 8'h2F;
   wire rd_b = REG_RD_IN && REG_ADDR_IN == 8'h30;
   AST_RVALID: assert property (REG_RD_IN |=> REG_RVALID_OUT)
      else $error("read not answered");
   AST_NOVALID: assert property (!REG_RD_IN |=> !REG_RVALID_OUT)
      else $error("answer without read");
   AST_INT_LOW: assert property (INT_PIN_OUT == 1'b0)
      else $error("interrupt data not low");
   AST_STAT_A: assert property (rd_a |=> REG_RDATA_OUT ==
      $past({CHAN_ENABLE_IN[2], CHAN_ENABLE_IN[3], 4'h0, g[0], g[1]})) else $error("bad status a");
   AST_STAT_B: assert property (rd_b |=> REG_RDATA_OUT[7:4] == $past({g[2], g[3], g[4], g[5]})
      && REG_RDATA_OUT[2] == 1'b0 && REG_RDATA_OUT[0] == 1'b0) else $error("bad status b");
   AST_LVL_RSV: assert property (REG_RD_IN && REG_ADDR_IN == 8'h31 |=>
      REG_RDATA_OUT[1:0] == 2'h0) else $error("level reserved set");
   AST_FLG_RSV: assert property (REG_RD_IN && REG_ADDR_IN == 8'h32 |=>
      (REG_RDATA_OUT & 8'hEC) == 8'h00) else $error("flag reserved set");
   AST_MSK_RSV: assert property (REG_RD_IN && REG_ADDR_IN == 8'h34 |=>
      (REG_RDATA_OUT & 8'hEC) == 8'h00) else $error("mask reserved set");
   AST_BUCK: assert property (REG_WR_IN && REG_ADDR_IN == 8'h36 |=> ##1
      {ADJ_DIRECTION_OUT, ADJ_CURRENT_CODE_OUT} == $past(REG_WDATA_IN[7] ?
      {1'b1, 7'h7F - REG_WDATA_IN[6:0]} : REG_WDATA_IN, 2)) else $error("bad adjust code");
   cover property (REG_RD_IN && REG_ADDR_IN == 8'h32 ##1 REG_RDATA_OUT != 8'h00);
   cover property (REG_WR_IN && REG_ADDR_IN == 8'h36 && REG_WDATA_IN[7]);
   cover property (rd_b ##1 REG_RDATA_OUT[7:4] != 4'h0);
endmodule // status_irq_regs_monitor
bind status_irq_regs status_irq_regs_monitor mon_u (.*);
`default_nettype wire

// ==== bench/status_irq_regs_tb_top.sv ====
// self-checking bench for the status and fault register bank
`timescale 1ns/1ns
`default_nettype none
module status_irq_regs_tb_top;
   logic        clk, rst, wr, rd_stb, rvalid, all_en, sp_mode, reen, laser_on, sup_good;
   logic        short_det, overtemp_warning_flag, ot_fault, int_d, int_oe, adj_dir;
   logic [3:0]  chan_en;
   logic [5:0]  out_en, lvl_set, lvl_out, g, lv;
   logic [6:0]  adj_code;
   logic [7:0]  addr, wdata, rdata, b;
   logic [31:0] d;
   logic [7:0]  exp_q[$];
   logic [15:0] rst_tab[7] = '{16'h2F00, 16'h300A, 16'h3100, 16'h3200, 16'h3400, 16'h3600,
                               16'h3300};
   logic [7:0]  fbit[3] = '{8'h10, 8'h02, 8'h01};
   int          n_errors = 0, num_checks = 0, cycles = 0, seed = 82164;
   assign g = out_en & {6{all_en}};
   assign lv = lvl_set & g;
   reg_host host_u (.clk_in(clk), .wr_out(wr), .rd_out(rd_stb), .addr_out(addr),
      .wdata_out(wdata));
   status_irq_regs dut_u (.CLOCK_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd_stb),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
      .CHAN_ENABLE_IN(chan_en), .ALL_OUTPUTS_ENABLE_IN(all_en), .OUT_ENABLE_IN(out_en),
      .OUT_LEVEL_SET_IN(lvl_set), .SHORT_PROTECT_MODE_IN(sp_mode), .REENABLE_IN(reen),
      .LASER_ON_INPUT_IN(laser_on), .SOURCE_SUPPLY_GOOD_IN(sup_good), .SHORT_DETECT_IN(short_det),
      .OT_WARNING_IN(overtemp_warning_flag), .OT_FAULT_IN(ot_fault), .OUT_LEVEL_OUT(lvl_out), .INT_PIN_OUT(int_d),
      .INT_PIN_OE_OUT(int_oe), .ADJ_DIRECTION_OUT(adj_dir), .ADJ_CURRENT_CODE_OUT(adj_code));
   task automatic check(input logic [7:0] seen, want);
      num_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back(e);
      host_u.xfer(1'b0, a, 8'h00);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(negedge clk) if (rvalid === 1'b1) check(rdata, exp_q.pop_front());
   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      {rst, laser_on, sup_good} = 3'h7;
      {chan_en, all_en, out_en, lvl_set, sp_mode, reen, short_det, overtemp_warning_flag, ot_fault} = 22'h0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      check({adj_dir, adj_code}, 8'h00);
      repeat (2) begin
         foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
         for (int a = 8'h2F; a < 8'h34; a++) host_u.xfer(1'b1, a[7:0], 8'hFF);
      end
      repeat (8) begin
         d = $random(seed);
         {chan_en, all_en, out_en, lvl_set, laser_on, sup_good} = d[18:0];
         host_u.xfer(1'b1, 8'h34, d[31:24]);
         host_u.xfer(1'b1, 8'h36, d[23:16]);
         // the adjust outputs follow the stored byte one edge later
         @(negedge clk);
         check({adj_dir, adj_code}, d[23] ? {1'b1, 7'h7F - d[22:16]} : d[23:16]);
         rd(8'h2F, {chan_en[2], chan_en[3], 4'h0, g[0], g[1]});
         rd(8'h30, {g[2], g[3], g[4], g[5], laser_on, 1'b0, sup_good, 1'b0});
         rd(8'h31, {lv[0], lv[1], lv[2], lv[3], lv[4], lv[5], 2'b00});
         rd(8'h34, d[31:24] & 8'h13);
         rd(8'h36, d[23:16]);
      end
      host_u.xfer(1'b1, 8'h34, 8'h00);
      for (int k = 0; k < 3; k++) begin
         b = fbit[k];
         {short_det, overtemp_warning_flag, ot_fault} = {b[4], b[1], b[0]};
         repeat (5) @(negedge clk);
         check({7'h00, int_oe}, 8'h01);
         rd(8'h32, b);
         host_u.xfer(1'b1, 8'h34, b);
         @(negedge clk);
         check({7'h00, int_oe}, 8'h00);
         host_u.xfer(1'b1, 8'h34, 8'h00);
         {short_det, overtemp_warning_flag, ot_fault} = 3'h0;
         repeat (5) @(negedge clk);
         check({7'h00, int_oe}, 8'h00);
      end
      sp_mode = 1'b1;
      short_det = 1'b1;
      repeat (5) @(negedge clk);
      short_det = 1'b0;
      repeat (5) @(negedge clk);
      rd(8'h32, 8'h10);
      reen = 1'b1;
      @(negedge clk);
      reen = 1'b0;
      rd(8'h32, 8'h00);
      check({7'h00, int_oe}, 8'h00);
      repeat (3) @(negedge clk);
      conclude();
   end
endmodule // status_irq_regs_tb_top
`default_nettype wire

// ==== inc/status_regs_map.vh ====
// register offsets, field positions and reset values of the status and fault bank
`ifndef STATUS_REGS_MAP_VH
`define STATUS_REGS_MAP_VH
`define ADDR_CHANNEL_STATUS_A  8'h2F
`define ADDR_OUTPUT_STATUS_B   8'h30
`define ADDR_LEVEL_READBACK    8'h31
`define ADDR_FAULT_FLAGS       8'h32
`define ADDR_FAULT_MASK        8'h34
`define ADDR_BUCK_ADJUST       8'h36
`define BIT_CHAN3_FLAG         7
`define BIT_CHAN4_FLAG         6
`define BIT_OUT1_FLAG          1
`define BIT_OUT2_FLAG          0
`define BIT_LASER_ON_FLAG      3
`define BIT_SUPPLY_GOOD        1
`define BIT_SHORT_CIRCUIT      4
`define BIT_OT_WARNING         1
`define BIT_OT_FAULT           0
`define BIT_ADJ_DIRECTION      7
`define FAULT_MASK_BITS        8'h13
`define RESET_BYTE             8'h00
`define RESET_STATUS_B         8'h0A
`define SINK_FULL_SCALE_CODE   7'h7F
`endif

// ==== verilog/short_latch.v ====
// short-circuit flag with auto-recover or latch-off behaviour
`timescale 1ns/1ns
`default_nettype none
module short_latch (
   input  wire clk_in,
   input  wire rst_in,
   input  wire short_in,
   input  wire latch_mode_in,
   input  wire reenable_in,
   output wire flag_out
);
   reg flag_q;
   reg flag_d;
   // set wins over re-enable so a fresh short is never lost
   always @* begin
      flag_d = flag_q;
      if (short_in)
         flag_d = 1'b1;
      else if (!latch_mode_in || reenable_in)
         flag_d = 1'b0;
   end
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         flag_q <= 1'b0;
      else
         flag_q <= flag_d;
   end
   assign flag_out = flag_q;
endmodule // short_latch
`default_nettype wire

// ==== verilog/status_irq_regs.v ====
// status, fault flag, mask and buck-adjust register bank of the quad laser source
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
`include "status_regs_map.vh"
`timescale 1ns/1ns
`default_nettype none
module status_irq_regs (
   // clock and reset
   input  wire       CLOCK_IN,
   input  wire       RST_IN,
   // register port from the serial interface logic
   input  wire       REG_WR_IN,
   input  wire       REG_RD_IN,
   input  wire [7:0] REG_ADDR_IN,
   input  wire [7:0] REG_WDATA_IN,
   output reg  [7:0] REG_RDATA_OUT,
   output reg        REG_RVALID_OUT,
   // enables from the control registers
   input  wire [3:0] CHAN_ENABLE_IN,
   input  wire       ALL_OUTPUTS_ENABLE_IN,
   input  wire [5:0] OUT_ENABLE_IN,
   input  wire [5:0] OUT_LEVEL_SET_IN,
   input  wire       SHORT_PROTECT_MODE_IN,
   input  wire       REENABLE_IN,
   // analog monitors, asynchronous
   input  wire       LASER_ON_INPUT_IN,
   input  wire       SOURCE_SUPPLY_GOOD_IN,
   input  wire       SHORT_DETECT_IN,
   input  wire       OT_WARNING_IN,
   input  wire       OT_FAULT_IN,
   // outputs to pins and analog
   output reg  [5:0] OUT_LEVEL_OUT,
   output reg        INT_PIN_OUT,
   output reg        INT_PIN_OE_OUT,
   output reg        ADJ_DIRECTION_OUT,
   output reg  [6:0] ADJ_CURRENT_CODE_OUT
);
   //----------------------------------------------------------------------
   // input synchronisation
   //----------------------------------------------------------------------
   wire [4:0] mon_sync;
   wire       short_sync;
   wire       laser_on_s;
   wire       supply_good_s;
   wire       overtemp_warning_flag_s;
   wire       ot_fault_s;
   // supply good and laser-on idle high so status b reads its default;
   // fault stages start clear so no false interrupt follows reset
   sync2 #(.WIDTH(5), .INIT(5'h18)) u_mon_sync (
      .clk_in (CLOCK_IN),
      .rst_in (RST_IN),
      .d_in   ({LASER_ON_INPUT_IN, SOURCE_SUPPLY_GOOD_IN, SHORT_DETECT_IN,
                OT_WARNING_IN, OT_FAULT_IN}),
      .q_out  (mon_sync)
   );
   assign laser_on_s    = mon_sync[4];
   assign supply_good_s = mon_sync[3];
   assign short_sync    = mon_sync[2];
   assign overtemp_warning_flag_s     = mon_sync[1];
   assign ot_fault_s    = mon_sync[0];

   //----------------------------------------------------------------------
   // short-circuit protection flag
   //----------------------------------------------------------------------
   wire short_circuit_flag;
   short_latch u_short_latch (
      .clk_in        (CLOCK_IN),
      .rst_in        (RST_IN),
      .short_in      (short_sync),
      .latch_mode_in (SHORT_PROTECT_MODE_IN),
      .reenable_in   (REENABLE_IN),
      .flag_out      (short_circuit_flag)
   );

   //----------------------------------------------------------------------
   // writable registers
   //----------------------------------------------------------------------
   reg [7:0] fault_interrupt_mask_q;
   reg [7:0] buck_adjust_current_q;
   always @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         fault_interrupt_mask_q <= `RESET_BYTE;
         buck_adjust_current_q  <= `RESET_BYTE;
      end else if (REG_WR_IN) begin
         // other addresses fall through untouched
         case (REG_ADDR_IN)
            `ADDR_FAULT_MASK: begin
               fault_interrupt_mask_q <= REG_WDATA_IN & `FAULT_MASK_BITS;
            end
            `ADDR_BUCK_ADJUST: begin
               buck_adjust_current_q <= REG_WDATA_IN;
            end
            default: begin
               fault_interrupt_mask_q <= fault_interrupt_mask_q;
            end
         endcase
      end
   end

   //----------------------------------------------------------------------
   // status composition
   //----------------------------------------------------------------------
   wire [5:0] out_enabled_flag;
   wire [7:0] channel_status_a;
   wire [7:0] output_status_b;
   wire [7:0] output_level_readback;
   wire [7:0] fault_flags;
   assign out_enabled_flag = OUT_ENABLE_IN & {6{ALL_OUTPUTS_ENABLE_IN}};
   assign channel_status_a = {CHAN_ENABLE_IN[2], CHAN_ENABLE_IN[3], 4'h0,
                              out_enabled_flag[0], out_enabled_flag[1]};
   assign output_status_b  = {out_enabled_flag[2], out_enabled_flag[3],
                              out_enabled_flag[4], out_enabled_flag[5],
                              laser_on_s, 1'b0, supply_good_s, 1'b0};
   assign output_level_readback = {OUT_LEVEL_OUT[0], OUT_LEVEL_OUT[1], OUT_LEVEL_OUT[2],
                                   OUT_LEVEL_OUT[3], OUT_LEVEL_OUT[4], OUT_LEVEL_OUT[5],
                                   2'h0};
   assign fault_flags = {3'h0, short_circuit_flag, 2'h0, overtemp_warning_flag_s, ot_fault_s};

   //----------------------------------------------------------------------
   // read port and pin outputs
   //----------------------------------------------------------------------
   reg [7:0] rdata_d;
   always @* begin
      case (REG_ADDR_IN)
         `ADDR_CHANNEL_STATUS_A: rdata_d = channel_status_a;
         `ADDR_OUTPUT_STATUS_B:  rdata_d = output_status_b;
         `ADDR_LEVEL_READBACK:   rdata_d = output_level_readback;
         `ADDR_FAULT_FLAGS:      rdata_d = fault_flags;
         `ADDR_FAULT_MASK:       rdata_d = fault_interrupt_mask_q;
         `ADDR_BUCK_ADJUST:      rdata_d = buck_adjust_current_q;
         default:                rdata_d = `RESET_BYTE;
      endcase
   end

   wire       irq_d;
   wire [6:0] code;
   assign irq_d = |(fault_flags & ~fault_interrupt_mask_q);
   assign code  = buck_adjust_current_q[6:0];

   always @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         REG_RDATA_OUT        <= `RESET_BYTE;
         REG_RVALID_OUT       <= 1'b0;
         OUT_LEVEL_OUT        <= 6'h00;
         INT_PIN_OUT          <= 1'b0;
         INT_PIN_OE_OUT       <= 1'b0;
         ADJ_DIRECTION_OUT    <= 1'b0;
         ADJ_CURRENT_CODE_OUT <= 7'h00;
      end else begin
         REG_RVALID_OUT <= REG_RD_IN;
         if (REG_RD_IN)
            REG_RDATA_OUT <= rdata_d;
         // a disabled output is held low
         OUT_LEVEL_OUT <= OUT_LEVEL_SET_IN & out_enabled_flag;
         INT_PIN_OUT    <= 1'b0;
         INT_PIN_OE_OUT <= irq_d;
         ADJ_DIRECTION_OUT <= buck_adjust_current_q[`BIT_ADJ_DIRECTION];
         // the dac is linear in its code, so sink reverses it: full scale minus code
         if (buck_adjust_current_q[`BIT_ADJ_DIRECTION])
            ADJ_CURRENT_CODE_OUT <= `SINK_FULL_SCALE_CODE - code;
         else
            ADJ_CURRENT_CODE_OUT <= code;
      end
   end
endmodule // status_irq_regs
`default_nettype wire

// ==== verilog/sync2.v ====
// two-flop level synchroniser, parameterised width
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             clk_in,
   input  wire             rst_in,
   input  wire [WIDTH-1:0] d_in,
   output wire [WIDTH-1:0] q_out
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end
   assign q_out = sync_q;
endmodule // sync2
`default_nettype wire
